// >>> src/isnc_pkg.sv
package isnc_pkg;

  // Decoded command set handed over by the text parser
  typedef enum logic [3:0] {
    OP_STATUS_QUERY           = 4'h0,
    OP_OVERLOAD_QUERY         = 4'h1,
    OP_NET_ADDRESS_CMD        = 4'h2,
    OP_NET_MASK_CMD           = 4'h3,
    OP_NET_GATEWAY_CMD        = 4'h4,
    OP_NET_ACCESS_LOCK_CMD    = 4'h5,
    OP_NET_ACCESS_UNLOCK_CMD  = 4'h6,
    OP_IDENTITY_QUERY         = 4'h7,
    OP_FIRMWARE_VERSION_QUERY = 4'h8,
    OP_CAL_DATE_QUERY         = 4'h9,
    OP_NAME_CMD               = 4'hA,
    OP_FACTORY_DEFAULT_CMD    = 4'hB,
    OP_PER_CHANNEL_CMD        = 4'hC,
    OP_EXPAND_CMD             = 4'hD,
    OP_SWEEP_CMD              = 4'hE,
    OP_UNUSED                 = 4'hF
  } isnc_op_t;

  // Gray coded along IDLE -> RESP -> IDLE and IDLE -> NAME_RD
  typedef enum logic [1:0] {
    FSM_IDLE    = 2'h0,
    FSM_RESP    = 2'h1,
    FSM_NAME_WR = 2'h3,
    FSM_NAME_RD = 2'h2
  } isnc_fsm_t;

  // Bit positions of command_status_flags
  localparam int STS_DONE     = 0;
  localparam int STS_BAD_CMD  = 1;
  localparam int STS_BAD_ARG  = 2;
  localparam int STS_REF_UNLK = 3;
  localparam int STS_OUT_OVL  = 4;
  localparam int STS_TRIG_NEW = 5;
  localparam int STS_IN_OVL   = 6;
  localparam int STS_DATA_AV  = 7;

  // Octet arguments given to the address commands
  localparam logic [6:0] NET_ARGC = 7'h04;

  // Factory default network settings
  localparam logic [31:0] DEF_ADDR = 32'hA9FE_000A;
  localparam logic [31:0] DEF_MASK = 32'hFFFF_0000;
  localparam logic [31:0] DEF_GW   = 32'hA9FE_0001;

  // Arguments of the factory default command
  localparam logic [31:0] DFLT_ALL      = 32'h0000_0000;
  localparam logic [31:0] DFLT_KEEP_COM = 32'h0000_0001;

  // Overload threshold in percent of full scale
  localparam logic [8:0] OVL_LIMIT_PCT = 9'h12C;
  localparam logic [8:0] PCT_FULL      = 9'h064;

  // Weights that pack day, month and year as a decimal number
  localparam logic [31:0] DATE_DAY_W = 32'h0000_2710;
  localparam logic [31:0] DATE_MON_W = 32'h0000_0064;

  // Classful boundaries for the derived mask
  localparam logic [7:0] CLASS_B_FIRST = 8'h80;
  localparam logic [7:0] CLASS_C_FIRST = 8'hC0;

endpackage

// >>> src/isnc_ovl_det.sv
`timescale 1ns/1ns
module isnc_ovl_det #(
  parameter int W = 16,
  parameter bit INCLUSIVE = 1'b0
) (
  // Output value and its full scale
  input wire logic signed [W-1:0] value_i,
  input wire logic [W-1:0] full_scale_i,
  // Overload flag
  output logic ovl_o
);
  import isnc_pkg::*;

  if (W < 2 || W > 48) begin : g_chk
    $error("isnc_ovl_det width out of range");
  end

  logic signed [W:0] ext;
  logic [W:0] mag;
  logic [W+9:0] lhs;
  logic [W+9:0] rhs;

  assign ext = {value_i[W-1], value_i};
  assign mag = ext[W] ? (-ext) : ext;
  // Widened so neither product can wrap
  assign lhs = (W+10)'(mag) * (W+10)'(PCT_FULL);
  assign rhs = (W+10)'(full_scale_i) * (W+10)'(OVL_LIMIT_PCT);
  assign ovl_o = INCLUSIVE ? (lhs >= rhs) : (lhs > rhs);
endmodule // isnc_ovl_det

// >>> src/isnc_net_default.sv
`timescale 1ns/1ns
module isnc_net_default (
  // Address being written
  input wire logic [31:0] addr_i,
  // Derived mask and gateway
  output logic [31:0] mask_o,
  output logic [31:0] gw_o
);
  import isnc_pkg::*;

  always_comb begin
    if (addr_i[31:24] < CLASS_B_FIRST) begin
      mask_o = 32'hFF00_0000;
    end else if (addr_i[31:24] < CLASS_C_FIRST) begin
      mask_o = 32'hFFFF_0000;
    end else begin
      mask_o = 32'hFFFF_FF00;
    end
    // First host of the subnet
    gw_o = (addr_i & mask_o) | 32'h0000_0001;
  end
endmodule // isnc_net_default

// >>> src/isnc_core.sv
`timescale 1ns/1ns
// Summary of operation
// - Status query returns done, invalid, param, unlock
// - Status bits five to seven: trigger, input, data
// - Status bit four is any output overload
// - Overload bits zero-three flag demodulator outputs
// - Overload bits four-seven flag auxiliary outputs
// - Address command reports active or stores static address
// - Address write rederives default mask and gateway
// - Mask command reports active or stores static mask
// - Gateway command reports active or stores static gateway
// - Stored settings apply only in static mode
// - Lock admits only the locking network host
// - Unlock admits every host again
// - Identity and firmware version queries return constants
// - Calibration date returns day, month, year digits
// - Name command stores or returns up to 64 chars
// - Default zero restores all, one keeps comms
// - Dual modes need channel suffix, no expand/sweep
module isnc_core #(
  parameter int VW = 16,
  parameter int NAME_MAX = 64,
  parameter logic [15:0] MODEL_CODE = 16'h0101, // Arbitrary value
  parameter logic [15:0] FW_VERSION = 16'h0001,
  parameter logic [7:0] CAL_DAY = 8'h01,
  parameter logic [7:0] CAL_MONTH = 8'h01,
  parameter logic [7:0] CAL_YEAR = 8'h00
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Decoded command from the parser
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire isnc_pkg::isnc_op_t cmd_op_i,
  input wire logic [1:0] cmd_chan_i,
  input wire logic [6:0] cmd_argc_i,
  input wire logic [31:0] cmd_arg_i,
  input wire logic cmd_from_net_i,
  input wire logic [31:0] cmd_src_addr_i,
  // Name characters following a name write
  input wire logic char_valid_i,
  input wire logic [7:0] char_i,
  // Response to the parser
  output logic rsp_valid_o,
  input wire logic rsp_ready_i,
  output logic [31:0] rsp_data_o,
  output logic rsp_last_o,
  // Forwarded per-channel, expand and sweep commands
  output logic fwd_valid_o,
  output isnc_pkg::isnc_op_t fwd_op_o,
  output logic [1:0] fwd_chan_o,
  // Instrument condition
  input wire logic ref_unlock_i,
  input wire logic adc_trig_done_i,
  input wire logic in_ovl_i,
  input wire logic data_avail_i,
  input wire logic dual_mode_i,
  input wire logic [3:0] aux_ovl_i,
  input wire logic signed [VW-1:0] out_x1_i,
  input wire logic signed [VW-1:0] out_y1_i,
  input wire logic signed [VW-1:0] out_x2_i,
  input wire logic signed [VW-1:0] out_y2_i,
  input wire logic [VW-1:0] full_scale_i,
  // Network side
  input wire logic static_mode_i,
  input wire logic [31:0] dyn_addr_i,
  input wire logic [31:0] dyn_mask_i,
  input wire logic [31:0] dyn_gw_i,
  input wire logic [31:0] conn_addr_i,
  output logic net_conn_ok_o,
  output logic [31:0] net_addr_o,
  output logic [31:0] net_mask_o,
  output logic [31:0] net_gw_o,
  // Visible flags
  output logic [7:0] status_flags_o,
  output logic [7:0] overload_flags_o
);
  import isnc_pkg::*;

  if (NAME_MAX < 1 || NAME_MAX > 127) begin : g_chk_name
    $error("isnc_core NAME_MAX out of range");
  end

  typedef struct packed {
    isnc_fsm_t fsm;
    logic done;
    logic bad_cmd;
    logic bad_arg;
    logic trig_new;
    logic [7:0] ovl;
    logic [31:0] addr;
    logic [31:0] mask;
    logic [31:0] gw;
    logic locked;
    logic [31:0] lock_addr;
    logic [6:0] name_len;
    logic [6:0] name_idx;
    logic [NAME_MAX-1:0][7:0] name;
    logic [31:0] rsp_data;
    logic rsp_valid;
    logic rsp_last;
    logic fwd_valid;
    isnc_op_t fwd_op;
    logic [1:0] fwd_chan;
    logic [31:0] act_addr;
    logic [31:0] act_mask;
    logic [31:0] act_gw;
  } isnc_core_t;

  isnc_core_t q;
  isnc_core_t next_q;

  logic [3:0] demod_ovl;
  logic [31:0] dflt_mask;
  logic [31:0] dflt_gw;
  logic net_ok;
  logic cmd_take;
  logic chan_ok;
  logic [7:0] status_byte;
  logic [31:0] cal_date;
  logic reply_en;
  logic [31:0] reply_val;
  logic signed [VW-1:0] demod_val [4];

  assign demod_val[0] = out_x1_i;
  assign demod_val[1] = out_y1_i;
  assign demod_val[2] = out_x2_i;
  assign demod_val[3] = out_y2_i;

  // Second demodulator limits are inclusive, first are strict
  for (genvar i = 0; i < 4; i++) begin : g_ovl
    isnc_ovl_det #(
      .W(VW),
      .INCLUSIVE(i >= 2)
    ) u_det (
      .value_i(demod_val[i]),
      .full_scale_i(full_scale_i),
      .ovl_o(demod_ovl[i])
    );
  end

  isnc_net_default u_dflt (
    .addr_i(cmd_arg_i),
    .mask_o(dflt_mask),
    .gw_o(dflt_gw)
  );

  // Locked link filters both connections and commands
  assign net_conn_ok_o = !q.locked || (conn_addr_i == q.lock_addr);
  assign net_ok = !cmd_from_net_i || !q.locked ||
                  (cmd_src_addr_i == q.lock_addr);
  assign cmd_ready_o = (q.fsm == FSM_IDLE);
  assign cmd_take = cmd_valid_i && cmd_ready_o;
  assign chan_ok = dual_mode_i ? (cmd_chan_i == 2'h1 || cmd_chan_i == 2'h2)
                               : (cmd_chan_i == 2'h0);

  always_comb begin
    status_byte = 8'h00;
    status_byte[STS_DONE] = q.done;
    status_byte[STS_BAD_CMD] = q.bad_cmd;
    status_byte[STS_BAD_ARG] = q.bad_arg;
    status_byte[STS_REF_UNLK] = ref_unlock_i;
    status_byte[STS_OUT_OVL] = |q.ovl;
    status_byte[STS_TRIG_NEW] = q.trig_new;
    status_byte[STS_IN_OVL] = in_ovl_i;
    status_byte[STS_DATA_AV] = data_avail_i || q.rsp_valid;
  end

  assign cal_date = 32'(CAL_DAY) * DATE_DAY_W +
                    32'(CAL_MONTH) * DATE_MON_W + 32'(CAL_YEAR);

  always_comb begin
    next_q = q;
    reply_en = 1'b0;
    reply_val = 32'h0000_0000;
    next_q.fwd_valid = 1'b0;
    next_q.ovl = {aux_ovl_i, demod_ovl};
    if (adc_trig_done_i) begin
      next_q.trig_new = 1'b1;
    end
    // Settings reach the network stack only in static mode
    next_q.act_addr = static_mode_i ? q.addr : dyn_addr_i;
    next_q.act_mask = static_mode_i ? q.mask : dyn_mask_i;
    next_q.act_gw = static_mode_i ? q.gw : dyn_gw_i;
    unique case (q.fsm)
      FSM_IDLE: begin
        if (cmd_take && net_ok) begin
          next_q.done = 1'b1;
          next_q.bad_cmd = 1'b0;
          next_q.bad_arg = 1'b0;
          unique case (cmd_op_i)
            OP_STATUS_QUERY: begin
              reply_en = 1'b1;
              reply_val = {24'h00_0000, status_byte};
              // A trigger in the reading cycle survives the clear
              next_q.trig_new = adc_trig_done_i;
            end
            OP_OVERLOAD_QUERY: begin
              reply_en = 1'b1;
              reply_val = {24'h00_0000, q.ovl};
            end
            OP_NET_ADDRESS_CMD: begin
              if (cmd_argc_i == 7'h00) begin
                reply_en = 1'b1;
                reply_val = q.act_addr;
              end else if (cmd_argc_i == NET_ARGC) begin
                next_q.addr = cmd_arg_i;
                next_q.mask = dflt_mask;
                next_q.gw = dflt_gw;
              end else begin
                next_q.bad_arg = 1'b1;
              end
            end
            OP_NET_MASK_CMD: begin
              if (cmd_argc_i == 7'h00) begin
                reply_en = 1'b1;
                reply_val = q.act_mask;
              end else if (cmd_argc_i == NET_ARGC) begin
                next_q.mask = cmd_arg_i;
              end else begin
                next_q.bad_arg = 1'b1;
              end
            end
            OP_NET_GATEWAY_CMD: begin
              if (cmd_argc_i == 7'h00) begin
                reply_en = 1'b1;
                reply_val = q.act_gw;
              end else if (cmd_argc_i == NET_ARGC) begin
                next_q.gw = cmd_arg_i;
              end else begin
                next_q.bad_arg = 1'b1;
              end
            end
            OP_NET_ACCESS_LOCK_CMD: begin
              // Only meaningful when it came over the network
              if (cmd_from_net_i) begin
                next_q.locked = 1'b1;
                next_q.lock_addr = cmd_src_addr_i;
              end
            end
            OP_NET_ACCESS_UNLOCK_CMD: begin
              if (cmd_from_net_i) begin
                next_q.locked = 1'b0;
              end
            end
            OP_IDENTITY_QUERY: begin
              reply_en = 1'b1;
              reply_val = {16'h0000, MODEL_CODE};
            end
            OP_FIRMWARE_VERSION_QUERY: begin
              reply_en = 1'b1;
              reply_val = {16'h0000, FW_VERSION};
            end
            OP_CAL_DATE_QUERY: begin
              reply_en = 1'b1;
              reply_val = cal_date;
            end
            OP_NAME_CMD: begin
              if (cmd_argc_i == 7'h00) begin
                next_q.name_idx = 7'h00;
                next_q.rsp_valid = 1'b1;
                next_q.rsp_data = (q.name_len == 7'h00) ? 32'h0000_0000
                                : {24'h00_0000, q.name[0]};
                next_q.rsp_last = (q.name_len <= 7'h01);
                next_q.fsm = FSM_NAME_RD;
              end else if (cmd_argc_i <= 7'(NAME_MAX)) begin
                next_q.name_idx = 7'h00;
                next_q.name_len = cmd_argc_i;
                next_q.fsm = FSM_NAME_WR;
              end else begin
                next_q.bad_arg = 1'b1;
              end
            end
            OP_FACTORY_DEFAULT_CMD: begin
              if (cmd_arg_i == DFLT_ALL) begin
                next_q.addr = DEF_ADDR;
                next_q.mask = DEF_MASK;
                next_q.gw = DEF_GW;
                next_q.locked = 1'b0;
                next_q.name_len = 7'h00;
              end else if (cmd_arg_i == DFLT_KEEP_COM) begin
                next_q.name_len = 7'h00;
              end else begin
                next_q.bad_arg = 1'b1;
              end
            end
            OP_PER_CHANNEL_CMD: begin
              if (chan_ok) begin
                next_q.fwd_valid = 1'b1;
                next_q.fwd_op = cmd_op_i;
                next_q.fwd_chan = cmd_chan_i;
              end else begin
                next_q.bad_cmd = 1'b1;
              end
            end
            OP_EXPAND_CMD, OP_SWEEP_CMD: begin
              if (!dual_mode_i && cmd_chan_i == 2'h0) begin
                next_q.fwd_valid = 1'b1;
                next_q.fwd_op = cmd_op_i;
                next_q.fwd_chan = 2'h0;
              end else begin
                next_q.bad_cmd = 1'b1;
              end
            end
            OP_UNUSED: begin
              next_q.bad_cmd = 1'b1;
            end
          endcase
          if (reply_en) begin
            next_q.rsp_valid = 1'b1;
            next_q.rsp_data = reply_val;
            next_q.rsp_last = 1'b1;
            next_q.fsm = FSM_RESP;
          end
        end
      end
      FSM_RESP: begin
        if (rsp_ready_i) begin
          next_q.rsp_valid = 1'b0;
          next_q.rsp_last = 1'b0;
          next_q.fsm = FSM_IDLE;
        end
      end
      FSM_NAME_WR: begin
        if (char_valid_i) begin
          next_q.name[q.name_idx] = char_i;
          next_q.name_idx = q.name_idx + 7'h01;
          if (q.name_idx + 7'h01 == q.name_len) begin
            next_q.fsm = FSM_IDLE;
          end
        end
      end
      FSM_NAME_RD: begin
        if (rsp_ready_i) begin
          if (q.rsp_last) begin
            next_q.rsp_valid = 1'b0;
            next_q.rsp_last = 1'b0;
            next_q.fsm = FSM_IDLE;
          end else begin
            next_q.name_idx = q.name_idx + 7'h01;
            next_q.rsp_data = {24'h00_0000, q.name[q.name_idx + 7'h01]};
            next_q.rsp_last = (q.name_idx + 7'h02 >= q.name_len);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q <= '0;
      q.fsm <= FSM_IDLE;
      q.addr <= DEF_ADDR;
      q.mask <= DEF_MASK;
      q.gw <= DEF_GW;
      q.fwd_op <= OP_STATUS_QUERY;
    end else begin
      q <= next_q;
    end
  end

  assign rsp_valid_o = q.rsp_valid;
  assign rsp_data_o = q.rsp_data;
  assign rsp_last_o = q.rsp_last;
  assign fwd_valid_o = q.fwd_valid;
  assign fwd_op_o = q.fwd_op;
  assign fwd_chan_o = q.fwd_chan;
  assign net_addr_o = q.act_addr;
  assign net_mask_o = q.act_mask;
  assign net_gw_o = q.act_gw;
  assign status_flags_o = status_byte;
  assign overload_flags_o = q.ovl;

  sequence s_take(isnc_op_t op);
    cmd_take && net_ok && cmd_op_i == op;
  endsequence

  sequence s_name_rd_start;
    s_take(OP_NAME_CMD) ##0 cmd_argc_i == 7'h00 ##0 q.name_len > 7'h01;
  endsequence

  a_status_ovl_bit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_take(OP_STATUS_QUERY) |=> rsp_valid_o &&
      rsp_data_o[STS_OUT_OVL] == |$past(q.ovl))
    else $error("status overload bit wrong");
  a_status_done_bit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_take(OP_STATUS_QUERY) ##1 !rsp_ready_i ##1 rsp_ready_i ##1 !cmd_take
      ##1 s_take(OP_STATUS_QUERY) |=> rsp_data_o[STS_DONE] &&
      !rsp_data_o[STS_BAD_CMD] && !rsp_data_o[STS_BAD_ARG])
    else $error("status done bit wrong");
  a_overload_byte: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_take(OP_OVERLOAD_QUERY) |=> rsp_data_o == {24'h00_0000, $past(q.ovl)})
    else $error("overload byte wrong");
  a_addr_rederive: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_take(OP_NET_ADDRESS_CMD) ##0 cmd_argc_i == NET_ARGC |=>
      q.addr == $past(cmd_arg_i) && q.gw[0] &&
      (q.gw & ~q.mask) == 32'h0000_0001)
    else $error("address write did not rederive");
  a_mask_keeps_addr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_take(OP_NET_MASK_CMD) ##0 cmd_argc_i == NET_ARGC |=>
      q.mask == $past(cmd_arg_i) && $stable(q.addr))
    else $error("mask write wrong");
  a_static_select: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    static_mode_i |=> net_addr_o == $past(q.addr) && net_gw_o == $past(q.gw))
    else $error("static settings not applied");
  a_lock_filter: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_take(OP_NET_ACCESS_LOCK_CMD) ##0 cmd_from_net_i ##1
      conn_addr_i != $past(cmd_src_addr_i) |-> !net_conn_ok_o)
    else $error("foreign host admitted while locked");
  a_unlock_opens: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_take(OP_NET_ACCESS_UNLOCK_CMD) ##0 cmd_from_net_i |=> net_conn_ok_o)
    else $error("unlock did not open access");
  a_bad_default: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_take(OP_FACTORY_DEFAULT_CMD) ##0 cmd_arg_i > DFLT_KEEP_COM |=>
      q.bad_arg && $stable(q.mask) && $stable(q.name_len))
    else $error("bad default argument accepted");
  a_dual_expand: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_take(OP_EXPAND_CMD) ##0 dual_mode_i |=> !fwd_valid_o && q.bad_cmd)
    else $error("expand ran in dual mode");
  a_name_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_name_rd_start |=> rsp_valid_o && !rsp_last_o &&
      rsp_data_o[7:0] == $past(q.name[0]))
    else $error("name read first char wrong");
endmodule // isnc_core

// >>> tb/isnc_host_model.sv
`timescale 1ns/1ns
module isnc_host_model (
  // Clock
  input wire logic clk_i,
  // Command to the handler
  output logic cmd_valid_o,
  input wire logic cmd_ready_i,
  output isnc_pkg::isnc_op_t cmd_op_o,
  output logic [1:0] cmd_chan_o,
  output logic [6:0] cmd_argc_o,
  output logic [31:0] cmd_arg_o,
  output logic cmd_from_net_o,
  output logic [31:0] cmd_src_addr_o,
  output logic char_valid_o,
  output logic [7:0] char_o,
  // Response from the handler
  input wire logic rsp_valid_i,
  output logic rsp_ready_o,
  input wire logic [31:0] rsp_data_i,
  input wire logic rsp_last_i
);
  import isnc_pkg::*;
  int lag = 0;
  initial begin
    cmd_valid_o = 1'b0;
    cmd_op_o = OP_UNUSED;
    cmd_chan_o = 2'h0;
    cmd_argc_o = 7'h00;
    cmd_arg_o = 32'h0;
    cmd_from_net_o = 1'b0;
    cmd_src_addr_o = 32'h0;
    char_valid_o = 1'b0;
    char_o = 8'h00;
    rsp_ready_o = 1'b0;
  end
  // Octets are packed into one word, never dot separated text
  task automatic send(input isnc_op_t op, input logic [1:0] ch,
      input logic [6:0] n, input logic [31:0] a, input logic net,
      input logic [31:0] src);
    int w;
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_op_o = op;
    cmd_chan_o = ch;
    cmd_argc_o = n;
    cmd_arg_o = a;
    cmd_from_net_o = net;
    cmd_src_addr_o = src;
    w = 0;
    while (!cmd_ready_i && w < 50) begin
      @(negedge clk_i);
      w++;
    end
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    // Released argument and source lines must not keep showing the old value
    cmd_arg_o = ~a;
    cmd_src_addr_o = ~src;
  endtask
  // Lag lets the host stall before accepting each beat
  task automatic get(output logic [31:0] d, output logic l);
    int w;
    d = 'x;
    l = 1'bx;
    w = 0;
    @(negedge clk_i);
    while (!rsp_valid_i && w < 50) begin
      @(negedge clk_i);
      w++;
    end
    repeat (lag) @(negedge clk_i);
    if (rsp_valid_i) begin
      d = rsp_data_i;
      l = rsp_last_i;
      rsp_ready_o = 1'b1;
      @(negedge clk_i);
      rsp_ready_o = 1'b0;
    end
  endtask
  task automatic name_wr(input string s);
    send(OP_NAME_CMD, 2'h0, 7'(s.len()), 32'h0, 1'b0, 32'h0);
    foreach (s[i]) begin
      char_valid_o = 1'b1;
      char_o = s[i];
      @(negedge clk_i);
    end
    char_valid_o = 1'b0;
    char_o = ~char_o;
  endtask
endmodule // isnc_host_model

// >>> tb/isnc_core_tb_top.sv
`timescale 1ns/1ns
module isnc_core_tb_top;
  import isnc_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, ref_unlock = 1'b0, trig = 1'b0;
  logic in_ovl = 1'b0, data_avail = 1'b0, dual = 1'b0, stat = 1'b1;
  logic [3:0] aux = 4'h0;
  logic signed [15:0] x1 = 16'h0, y1 = 16'h0, x2 = 16'h0, y2 = 16'h0;
  logic [15:0] fs = 16'h0064;
  logic [31:0] dyn_a = 32'hC0A80105, dyn_m = 32'hFFFFFF00;
  logic [31:0] dyn_g = 32'hC0A80101, conn = 32'h0;
  logic cv, cr, fn, chv, rv, rr, rl, fv, ok;
  isnc_op_t op, fop;
  logic [1:0] ch, fch;
  logic [6:0] argc;
  logic [31:0] arg, src, rd, na, nm, ng, d;
  logic [7:0] chr, sts, ovl;
  logic l;
  int miscompares = 0, samples_checked = 0;
  localparam logic [31:0] A = 32'h0A010203, HA = 32'h0000000A;
  localparam logic [31:0] HB = 32'h0000000B;
  always #2 clk = ~clk;
  isnc_core #(.CAL_DAY(8'h1F), .CAL_MONTH(8'h0C), .CAL_YEAR(8'h18))
  u_isnc_core (.clk_i(clk), .sys_rst_i(sys_rst), .cmd_valid_i(cv),
    .cmd_ready_o(cr), .cmd_op_i(op), .cmd_chan_i(ch), .cmd_argc_i(argc),
    .cmd_arg_i(arg), .cmd_from_net_i(fn), .cmd_src_addr_i(src),
    .char_valid_i(chv), .char_i(chr), .rsp_valid_o(rv), .rsp_ready_i(rr),
    .rsp_data_o(rd), .rsp_last_o(rl), .fwd_valid_o(fv), .fwd_op_o(fop),
    .fwd_chan_o(fch), .ref_unlock_i(ref_unlock), .adc_trig_done_i(trig),
    .in_ovl_i(in_ovl), .data_avail_i(data_avail), .dual_mode_i(dual),
    .aux_ovl_i(aux), .out_x1_i(x1), .out_y1_i(y1), .out_x2_i(x2),
    .out_y2_i(y2), .full_scale_i(fs), .static_mode_i(stat),
    .dyn_addr_i(dyn_a), .dyn_mask_i(dyn_m), .dyn_gw_i(dyn_g),
    .conn_addr_i(conn), .net_conn_ok_o(ok), .net_addr_o(na),
    .net_mask_o(nm), .net_gw_o(ng), .status_flags_o(sts),
    .overload_flags_o(ovl));
  isnc_host_model u_isnc_host_model (.clk_i(clk), .cmd_valid_o(cv),
    .cmd_ready_i(cr), .cmd_op_o(op), .cmd_chan_o(ch), .cmd_argc_o(argc),
    .cmd_arg_o(arg), .cmd_from_net_o(fn), .cmd_src_addr_o(src),
    .char_valid_o(chv), .char_o(chr), .rsp_valid_i(rv), .rsp_ready_o(rr),
    .rsp_data_i(rd), .rsp_last_i(rl));
  task automatic chk(input logic [31:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %0t %s", $time, m);
      miscompares++;
    end
  endtask
  task automatic snd(isnc_op_t o, logic [1:0] c, logic [6:0] n,
      logic [31:0] a, logic net, logic [31:0] s);
    u_isnc_host_model.send(o, c, n, a, net, s);
  endtask
  task automatic ask(input isnc_op_t o, output logic [31:0] r);
    snd(o, 2'h0, 7'h00, 32'h0, 1'b0, 32'h0);
    u_isnc_host_model.get(r, l);
  endtask
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask
  task automatic summarize();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic t_net();
    settle();
    chk(na, DEF_ADDR, "reset address");
    // Address first, since it rewrites mask and gateway
    snd(OP_NET_ADDRESS_CMD, 2'h0, NET_ARGC, A, 1'b0, 32'h0);
    settle();
    chk(na, A, "static address");
    chk(nm, 32'hFF000000, "derived mask");
    chk(ng, 32'h0A000001, "derived gateway");
    snd(OP_NET_MASK_CMD, 2'h0, NET_ARGC, 32'hFFFF0000, 1'b0, 32'h0);
    snd(OP_NET_GATEWAY_CMD, 2'h0, NET_ARGC, 32'h0A0100FE, 1'b0, 32'h0);
    snd(OP_NET_ADDRESS_CMD, 2'h0, 7'h03, 32'h0, 1'b0, 32'h0);
    settle();
    chk(nm, 32'hFFFF0000, "mask kept");
    chk(ng, 32'h0A0100FE, "gateway kept");
    chk(na, A, "address kept");
    ask(OP_STATUS_QUERY, d);
    chk(d & 32'h7, 32'h5, "parameter error");
    stat = 1'b0;
    settle();
    chk(na, dyn_a, "dynamic address");
    ask(OP_NET_ADDRESS_CMD, d);
    chk(d, dyn_a, "address report");
    stat = 1'b1;
  endtask
  task automatic t_lock();
    snd(OP_NET_ACCESS_LOCK_CMD, 2'h0, 7'h00, 32'h0, 1'b1, HA);
    conn = HB;
    @(negedge clk);
    chk({31'h0, ok}, 32'h0, "foreign host refused");
    conn = HA;
    @(negedge clk);
    chk({31'h0, ok}, 32'h1, "locking host admitted");
    snd(OP_NET_ADDRESS_CMD, 2'h0, NET_ARGC, 32'h0B000001, 1'b1, HB);
    settle();
    chk(na, A, "foreign command dropped");
    snd(OP_NET_ACCESS_UNLOCK_CMD, 2'h0, 7'h00, 32'h0, 1'b1, HA);
    conn = HB;
    @(negedge clk);
    chk({31'h0, ok}, 32'h1, "any host admitted");
  endtask
  task automatic t_default();
    snd(OP_FACTORY_DEFAULT_CMD, 2'h0, 7'h01, DFLT_KEEP_COM, 1'b0, 32'h0);
    settle();
    chk(na, A, "comms kept");
    snd(OP_FACTORY_DEFAULT_CMD, 2'h0, 7'h01, DFLT_ALL, 1'b0, 32'h0);
    settle();
    chk(na, DEF_ADDR, "address restored");
    chk(nm, DEF_MASK, "mask restored");
    snd(OP_FACTORY_DEFAULT_CMD, 2'h0, 7'h01, 32'h2, 1'b0, 32'h0);
    ask(OP_STATUS_QUERY, d);
    chk(d & 32'h7, 32'h5, "default argument refused");
    chk(nm, DEF_MASK, "mask untouched");
  endtask
  task automatic t_status();
    ref_unlock = 1'b1;
    in_ovl = 1'b1;
    data_avail = 1'b1;
    trig = 1'b1;
    @(negedge clk);
    trig = 1'b0;
    ask(OP_STATUS_QUERY, d);
    chk(d & 32'hE8, 32'hE8, "condition bits");
    ask(OP_STATUS_QUERY, d);
    chk(d & 32'h21, 32'h01, "trigger cleared, done");
    ref_unlock = 1'b0;
    in_ovl = 1'b0;
    data_avail = 1'b0;
  endtask
  task automatic t_overload();
    // Exactly 300 percent trips only the second pair of outputs
    x1 = 16'sd300;
    y1 = 16'sd301;
    x2 = -16'sd300;
    aux = 4'h9;
    settle();
    ask(OP_OVERLOAD_QUERY, d);
    chk(d, 32'h96, "overload byte");
    chk({24'h0, ovl}, 32'h96, "overload flags");
    chk({31'h0, sts[4]}, 32'h1, "output overload");
    x1 = 16'sd0;
    y1 = 16'sd0;
    x2 = 16'sd0;
    aux = 4'h0;
    settle();
    chk({31'h0, sts[4]}, 32'h0, "overload gone");
  endtask
  task automatic t_ident();
    u_isnc_host_model.lag = 2;
    ask(OP_IDENTITY_QUERY, d);
    chk(d & 32'hFFFF, 32'h0101, "identity");
    ask(OP_FIRMWARE_VERSION_QUERY, d);
    chk(d & 32'hFFFF, 32'h0001, "firmware");
    ask(OP_CAL_DATE_QUERY, d);
    chk(d, 31 * 10000 + 12 * 100 + 24, "calibration date");
    u_isnc_host_model.lag = 0;
  endtask
  task automatic t_name();
    u_isnc_host_model.name_wr("AB");
    ask(OP_NAME_CMD, d);
    chk({23'h0, l, d[7:0]}, 32'h041, "name first char");
    u_isnc_host_model.get(d, l);
    chk({23'h0, l, d[7:0]}, 32'h142, "name last char");
  endtask
  task automatic t_dual();
    dual = 1'b1;
    snd(OP_PER_CHANNEL_CMD, 2'h1, 7'h00, 32'h0, 1'b0, 32'h0);
    chk({29'h0, fv, fch}, 32'h5, "forward channel one");
    chk({28'h0, fop}, 32'hC, "forward op");
    snd(OP_EXPAND_CMD, 2'h0, 7'h00, 32'h0, 1'b0, 32'h0);
    ask(OP_STATUS_QUERY, d);
    chk(d & 32'h7, 32'h3, "expand refused");
    dual = 1'b0;
    snd(OP_SWEEP_CMD, 2'h0, 7'h00, 32'h0, 1'b0, 32'h0);
    chk({29'h0, fv, fch}, 32'h4, "sweep in single mode");
    chk({28'h0, fop}, 32'hE, "sweep forwarded");
  endtask
  initial begin
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    t_net();
    t_lock();
    t_default();
    t_status();
    t_overload();
    t_ident();
    t_name();
    t_dual();
    summarize();
  end
  initial begin
    #40000;
    miscompares++;
    summarize();
  end
endmodule // isnc_core_tb_top
